// ### core/lin_hdr_pkg.sv
// Constants and types shared by the LIN header serial block
package lin_hdr_pkg;
  localparam logic [3:0] STATUS_ADDR = 4'h0;
  localparam logic [3:0] DATA_ADDR   = 4'h1;
  localparam logic [3:0] CTRL1_ADDR  = 4'h2;
  localparam logic [3:0] CTRL2_ADDR  = 4'h3;
  localparam logic [3:0] CTRL3_ADDR  = 4'h4;
  localparam logic [3:0] BAUD_ADDR   = 4'h5;
  localparam logic [3:0] EXT_RX_ADDR = 4'h6;
  localparam logic [3:0] EXT_TX_ADDR = 4'h7;
  // Status bit positions
  localparam int ST_TX_EMPTY = 7;
  localparam int ST_RX_FULL  = 5;
  localparam int ST_OVERRUN  = 3;
  localparam int ST_PAR_ERR  = 2;
  localparam int ST_FRAME    = 1;
  localparam int ST_HDR_ERR  = 0;
  // Control bit positions
  localparam int C1_NINE_BIT = 4;
  localparam int C1_PAR_EN   = 2;
  localparam int C2_RX_IRQ   = 5;
  localparam int C2_BREAK    = 0;
  localparam int C3_HDF      = 7;
  localparam int C3_HIE      = 6;
  localparam int C3_SLAVE    = 5;
  localparam int C3_LIN_EN   = 4;
  localparam int C3_HDM      = 3;
  localparam int C3_AUTO     = 2;
  localparam int C3_BLOCKED  = 1;
  // Reset values
  localparam logic [7:0]  REG_RESET   = 8'h00;
  localparam logic [11:0] SDIV_RESET  = 12'h000;
  // Character and timing figures
  localparam logic [7:0]  SYNC_BYTE   = 8'h55;
  localparam logic [7:0]  BREAK_DATA  = 8'h00;
  localparam logic [3:0]  SAMPLE_MID  = 4'h7;
  localparam logic [3:0]  SAMPLE_LAST = 4'hf;
  localparam logic [3:0]  TX_BRK_BITS = 4'hd;
  localparam logic [11:0] BRK_MIN_TCK = 12'h0b0;
  localparam logic [7:0]  HDR_TMO_BIT = 8'h39;
  localparam logic [2:0]  SYNC_EDGES  = 3'h5;
  localparam logic [15:0] PRE_FAC     = 16'hd431;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef enum {R_IDLE, R_START, R_DATA, R_STOP, R_BRK} rx_state_t;
  typedef enum {T_IDLE, T_SHIFT, T_BRK} tx_state_t;
  typedef enum {H_IDLE, H_MEAS, H_SYNC, H_ID, H_BLOCK} hdr_state_t;
endpackage

// ### core/lin_serial_header_logic.sv
// LIN header serial block: prescalers, break, sync measurement, header checks
// Notes on behaviour
// - Nonzero extended prescaler divides baud clock
// - Extended prescalers reset to zero, inactive
// - Slave mode uses one LIN divider both ways
// - Master send break emits thirteen low bits
// - Slave mode ignores send break writes
// - Method zero: break sets flags, zero data
// - Auto resync hides sync byte from data
// - Method one: flags after full header only
// - Receiver halted during sync measurement
// - Slave frame error except on break
// - Check identifier parity bits when enabled
// - Header error sets flag and interrupt
// - Status access then data read clears error
// - No resync: sync mismatch, overrun errors; timeout only in method one
// - Resync: deviation, timeout, overrun, overflow errors
// - Span check between first and last edge
// - Per-interval check, failure blocks header tracking
// - LIN mode remaps three register addresses
// - Break needs eleven low bits then high
// - Header must complete within 57 bit times
// - Slave bit rate uses 8.4 fixed divider
// - Measure five falling edges, update divider
`timescale 1ns/1ps
`default_nettype none

module lin_rate_div
  import lin_hdr_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] pre_sel,
  input  wire logic [2:0] rate_sel,
  input  wire logic [7:0] ext_div,
  output logic            tick
);
  logic [10:0] cnt_reg;
  logic [7:0]  ecnt_reg;
  wire  [3:0]  pre_fac   = PRE_FAC[{pre_sel, 2'b00} +: 4];
  wire  [10:0] lim       = 11'({7'h00, pre_fac} << rate_sel);
  wire         conv_tick = (cnt_reg == lim - 11'h001);
  wire         ext_last  = (ecnt_reg == ext_div - 8'h01);

  assign tick = conv_tick & ((ext_div == 8'h00) | ext_last);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg  <= 11'h000;
      ecnt_reg <= 8'h00;
    end else begin
      cnt_reg <= conv_tick ? 11'h000 : cnt_reg + 11'h001;
      if (conv_tick)
        ecnt_reg <= (ext_last || ext_div == 8'h00) ? 8'h00 : ecnt_reg + 8'h01;
    end
  end
endmodule

module lin_serial_header_logic
  import lin_hdr_pkg::*;
(
  input  wire logic      ref_clk,
  input  wire logic      rst_n,
  input  wire reg_req_t  reg_req,
  output logic [7:0]     rd_data,
  input  wire logic      rx_data_in,
  output logic           tx_data_out,
  input  wire logic      cpu_irq_mask,
  output logic           irq_out
);
  logic [7:0]  status_reg, data_reg, ctrl_reg1, ctrl_reg2, ctrl_reg3, baud_reg;
  logic [7:0]  ext_rx_prescaler, ext_tx_prescaler, header_length_reg, tx_hold_reg;
  logic [11:0] slave_divider;
  logic [11:0] sacc_reg;
  logic        stat_seen_reg, rx_prev_reg, brk_pend_reg, irq_reg;
  logic [7:0]  rd_data_reg;
  rx_state_t   rx_state;
  tx_state_t   tx_state;
  hdr_state_t  hdr_state;
  logic [3:0]  rcnt_reg, tsub_reg, tbits_reg, bsub_reg;
  logic [2:0]  rbit_reg, edge_cnt_reg;
  logic [7:0]  rsh_reg, tmo_reg;
  logic [9:0]  tsh_reg;
  logic [11:0] low_reg;
  logic [14:0] meas_reg, last_edge_reg;
  logic        tx_out_reg;
  logic        conv_rx_tick, conv_tx_tick;

  // Register decode
  wire lin_en      = ctrl_reg3[C3_LIN_EN];
  wire slave_mode  = lin_en & ctrl_reg3[C3_SLAVE];
  wire hdm         = ctrl_reg3[C3_HDM];
  wire auto_rs     = ctrl_reg3[C3_AUTO];
  wire wr_stat     = reg_req.wr & (reg_req.addr == STATUS_ADDR);
  wire wr_data     = reg_req.wr & (reg_req.addr == DATA_ADDR);
  wire wr_c1       = reg_req.wr & (reg_req.addr == CTRL1_ADDR);
  wire wr_c2       = reg_req.wr & (reg_req.addr == CTRL2_ADDR);
  wire wr_c3       = reg_req.wr & (reg_req.addr == CTRL3_ADDR);
  wire wr_baud     = reg_req.wr & (reg_req.addr == BAUD_ADDR);
  wire wr_erx      = reg_req.wr & (reg_req.addr == EXT_RX_ADDR);
  wire wr_etx      = reg_req.wr & (reg_req.addr == EXT_TX_ADDR);
  wire rd_stat     = reg_req.rd & (reg_req.addr == STATUS_ADDR);
  wire rd_dat      = reg_req.rd & (reg_req.addr == DATA_ADDR);
  wire clr_seq     = rd_dat & stat_seen_reg;
  wire [7:0] wd    = reg_req.wdata;

  // LIN mode swaps three addresses onto the slave divider and header length
  wire [7:0] rd_mux =
    (reg_req.addr == STATUS_ADDR) ? status_reg :
    (reg_req.addr == DATA_ADDR)   ? data_reg :
    (reg_req.addr == CTRL1_ADDR)  ? ctrl_reg1 :
    (reg_req.addr == CTRL2_ADDR)  ? ctrl_reg2 :
    (reg_req.addr == CTRL3_ADDR)  ? ctrl_reg3 :
    (reg_req.addr == BAUD_ADDR)   ? (lin_en ? slave_divider[11:4] : baud_reg) :
    (reg_req.addr == EXT_RX_ADDR) ? (lin_en ? header_length_reg : ext_rx_prescaler) :
    (reg_req.addr == EXT_TX_ADDR) ? (lin_en ? {4'h0, slave_divider[3:0]} :
                                     ext_tx_prescaler) : 8'h00;

  // Baud clocks
  lin_rate_div u_rx_div (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .pre_sel  (baud_reg[7:6]),
    .rate_sel (baud_reg[2:0]),
    .ext_div  (ext_rx_prescaler),
    .tick     (conv_rx_tick)
  );
  lin_rate_div u_tx_div (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .pre_sel  (baud_reg[7:6]),
    .rate_sel (baud_reg[5:3]),
    .ext_div  (ext_tx_prescaler),
    .tick     (conv_tx_tick)
  );
  // Sample tick every slave_divider/16 clocks, fraction kept in accumulator
  wire [12:0] sacc_sum = {1'b0, sacc_reg} + 13'h0010;
  wire        s_tick   = (slave_divider != 12'h000) & (sacc_sum >= {1'b0, slave_divider});
  wire        rx_tick  = slave_mode ? s_tick : conv_rx_tick;
  wire        tx_tick  = slave_mode ? s_tick : conv_tx_tick;
  wire        rbit_tick = rx_tick & (bsub_reg == SAMPLE_LAST);
  wire        tbit_tick = tx_tick & (tsub_reg == SAMPLE_LAST);

  // Receiver events
  wire fall      = rx_prev_reg & ~rx_data_in;
  wire rx_halt   = (hdr_state == H_MEAS);
  wire stop_done = (rx_state == R_STOP) & rx_tick & (rcnt_reg == SAMPLE_LAST);
  wire zero_chr  = (rsh_reg == BREAK_DATA);
  wire char_evt  = stop_done & rx_data_in;
  wire brk_cand  = stop_done & ~rx_data_in & zero_chr & lin_en;
  wire brk_end   = (rx_state == R_BRK) & rx_data_in;
  wire brk_evt   = brk_end & (low_reg >= BRK_MIN_TCK);
  wire fe_evt    = (stop_done & ~rx_data_in & ~(zero_chr & lin_en))
                 | (brk_end & ~brk_evt);

  // Header tracking
  wire in_sync   = (hdr_state == H_SYNC);
  wire in_id     = (hdr_state == H_ID);
  wire hdr_busy  = in_sync | in_id | rx_halt;
  wire id_evt    = in_id & char_evt & slave_mode;
  wire sync_bad  = in_sync & char_evt & (rsh_reg != SYNC_BYTE);
  wire deliver   = char_evt & ~(slave_mode & hdm & in_sync)
                 | (brk_evt & ~(slave_mode & hdm));
  wire ovr_evt   = deliver & status_reg[ST_RX_FULL];
  wire tmo_evt   = slave_mode & hdr_busy & (hdm | auto_rs)
                 & rbit_tick & (tmo_reg == HDR_TMO_BIT - 8'h01);
  // Identifier parity: bit 6 even over 0,1,2,4; bit 7 odd over 1,3,4,5
  wire p6        = rsh_reg[0] ^ rsh_reg[1] ^ rsh_reg[2] ^ rsh_reg[4];
  wire p7        = ~(rsh_reg[1] ^ rsh_reg[3] ^ rsh_reg[4] ^ rsh_reg[5]);
  wire par_evt   = id_evt & ctrl_reg1[C1_PAR_EN]
                 & ((rsh_reg[6] != p6) | (rsh_reg[7] != p7));

  // Sync field measurement in CPU clocks
  wire [11:0] div_sum  = slave_divider;
  wire [14:0] nom8     = {div_sum, 3'b000};
  wire [14:0] span_tol = {3'b000, nom8[14:3]} + {5'h00, nom8[14:5]};
  wire [14:0] span_dif = (meas_reg > nom8) ? meas_reg - nom8 : nom8 - meas_reg;
  wire [14:0] nom2     = {2'b00, div_sum, 1'b0};
  wire [14:0] int_min  = nom2 - {3'b000, nom2[14:3]} - {5'h00, nom2[14:5]};
  wire [14:0] interval = meas_reg - last_edge_reg;
  wire meas_on   = rx_halt & (edge_cnt_reg != 3'h0);
  wire edge_next = rx_halt & fall & (edge_cnt_reg != 3'h0);
  wire int_err   = edge_next & (interval < int_min);
  wire last_edge = edge_next & (edge_cnt_reg == SYNC_EDGES - 3'h1);
  wire span_err  = last_edge & (span_dif > span_tol);
  wire meas_ovf  = meas_on & (meas_reg == 15'h7fff);
  wire meas_ok   = last_edge & ~span_err & ~int_err;
  wire blk_evt   = int_err | meas_ovf | (tmo_evt & rx_halt & auto_rs);
  wire hdr_err   = slave_mode & (sync_bad & ~auto_rs | ovr_evt & ~rx_halt | tmo_evt
                 | span_err | blk_evt);

  assign rd_data     = rd_data_reg;
  assign tx_data_out = tx_out_reg;
  assign irq_out     = irq_reg;

  // Register file
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg1        <= REG_RESET;
      ctrl_reg2        <= REG_RESET;
      baud_reg         <= REG_RESET;
      ext_rx_prescaler <= REG_RESET;
      ext_tx_prescaler <= REG_RESET;
      rd_data_reg      <= REG_RESET;
      stat_seen_reg    <= 1'b0;
    end else begin
      if (wr_c1) ctrl_reg1 <= wd;
      if (wr_c2) ctrl_reg2 <= wd;
      if (wr_baud && !lin_en) baud_reg <= wd;
      if (wr_erx && !lin_en) ext_rx_prescaler <= wd;
      if (wr_etx && !lin_en) ext_tx_prescaler <= wd;
      rd_data_reg <= reg_req.rd ? rd_mux : 8'h00;
      if (rd_stat || wr_stat) stat_seen_reg <= 1'b1;
      else if (rd_dat) stat_seen_reg <= 1'b0;
    end
  end

  // Control 3 with hardware flags; a set beats a software clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg3 <= REG_RESET;
    end else begin
      if (wr_c3) ctrl_reg3 <= {wd[7] & ctrl_reg3[7], wd[6:2], wd[1] & ctrl_reg3[1], 1'b0};
      if (slave_mode && ((brk_evt && !hdm) || (id_evt && hdm)))
        ctrl_reg3[C3_HDF] <= 1'b1;
      if (blk_evt && slave_mode && auto_rs) ctrl_reg3[C3_BLOCKED] <= 1'b1;
    end
  end

  // Status and data
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= 8'h80;
      data_reg   <= REG_RESET;
      tx_hold_reg <= REG_RESET;
    end else begin
      if (clr_seq) begin
        status_reg[ST_RX_FULL] <= 1'b0;
        status_reg[ST_OVERRUN] <= 1'b0;
        status_reg[ST_PAR_ERR] <= 1'b0;
        status_reg[ST_FRAME]   <= 1'b0;
        status_reg[ST_HDR_ERR] <= 1'b0;
      end
      if (wr_data) begin
        tx_hold_reg <= wd;
        status_reg[ST_TX_EMPTY] <= 1'b0;
      end else if (tx_state == T_IDLE && tbit_tick && !brk_pend_reg
                   && !status_reg[ST_TX_EMPTY]) begin
        status_reg[ST_TX_EMPTY] <= 1'b1;
      end
      if (deliver && !ovr_evt) begin
        data_reg <= brk_evt ? BREAK_DATA : rsh_reg;
        status_reg[ST_RX_FULL] <= 1'b1;
      end
      if (ovr_evt) status_reg[ST_OVERRUN] <= 1'b1;
      if (par_evt) status_reg[ST_PAR_ERR] <= 1'b1;
      if (fe_evt) status_reg[ST_FRAME] <= 1'b1;
      if (hdr_err) status_reg[ST_HDR_ERR] <= 1'b1;
    end
  end

  // Slave divider: software write wins over a measured update
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      slave_divider <= SDIV_RESET;
    end else if (lin_en && (wr_baud || wr_etx)) begin
      if (wr_baud) slave_divider[11:4] <= wd;
      if (wr_etx) slave_divider[3:0] <= wd[3:0];
    end else if (meas_ok && auto_rs) begin
      slave_divider <= meas_reg[14:3];
    end
  end

  // Clock dividers and interrupt
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sacc_reg    <= 12'h000;
      bsub_reg    <= 4'h0;
      tsub_reg    <= 4'h0;
      rx_prev_reg <= 1'b1;
      irq_reg     <= 1'b0;
    end else begin
      sacc_reg <= s_tick ? 12'(sacc_sum - {1'b0, slave_divider}) : sacc_sum[11:0];
      if (rx_tick) bsub_reg <= bsub_reg + 4'h1;
      if (tx_tick) tsub_reg <= tsub_reg + 4'h1;
      rx_prev_reg <= rx_data_in;
      irq_reg <= ~cpu_irq_mask & ((ctrl_reg3[C3_HDF] & ctrl_reg3[C3_HIE])
               | (ctrl_reg2[C2_RX_IRQ] & (status_reg[ST_HDR_ERR]
               | status_reg[ST_RX_FULL] | status_reg[ST_OVERRUN])));
    end
  end

  // Receive state machine, sixteen ticks per bit
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_state <= R_IDLE;
      rcnt_reg <= 4'h0;
      rbit_reg <= 3'h0;
      rsh_reg  <= 8'h00;
      low_reg  <= 12'h000;
    end else begin
      if (rx_data_in) low_reg <= 12'h000;
      else if (rx_tick && low_reg != 12'hfff) low_reg <= low_reg + 12'h001;
      if (rx_tick) rcnt_reg <= rcnt_reg + 4'h1;
      case (rx_state)
        R_IDLE: begin
          if (fall && !rx_halt) begin
            rx_state <= R_START;
            rcnt_reg <= 4'h0;
          end
        end
        R_START: begin
          if (rx_tick && rcnt_reg == SAMPLE_MID) begin
            rx_state <= rx_data_in ? R_IDLE : R_DATA;
            rcnt_reg <= 4'h0;
            rbit_reg <= 3'h0;
          end
        end
        R_DATA: begin
          if (rx_tick && rcnt_reg == SAMPLE_LAST) begin
            rsh_reg  <= {rx_data_in, rsh_reg[7:1]};
            rbit_reg <= rbit_reg + 3'h1;
            if (rbit_reg == 3'h7) rx_state <= R_STOP;
          end
        end
        R_STOP: begin
          if (stop_done) rx_state <= brk_cand ? R_BRK : R_IDLE;
        end
        R_BRK: begin
          if (rx_data_in) rx_state <= R_IDLE;
        end
        default: rx_state <= R_IDLE;
      endcase
    end
  end

  // Header tracking, sync measurement and time-out
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hdr_state         <= H_IDLE;
      tmo_reg           <= 8'h00;
      header_length_reg <= REG_RESET;
      meas_reg          <= 15'h0000;
      last_edge_reg     <= 15'h0000;
      edge_cnt_reg      <= 3'h0;
    end else begin
      if (rbit_tick && tmo_reg != 8'hff) tmo_reg <= tmo_reg + 8'h01;
      if (meas_on && !meas_ovf) meas_reg <= meas_reg + 15'h0001;
      case (hdr_state)
        H_IDLE: ;
        H_MEAS: begin
          if (fall && edge_cnt_reg == 3'h0) begin
            edge_cnt_reg  <= 3'h1;
            meas_reg      <= 15'h0001;
            last_edge_reg <= 15'h0000;
          end else if (edge_next) begin
            edge_cnt_reg  <= edge_cnt_reg + 3'h1;
            last_edge_reg <= meas_reg;
          end
          if (blk_evt) hdr_state <= H_BLOCK;
          else if (span_err) hdr_state <= H_IDLE;
          else if (last_edge) hdr_state <= H_ID;
        end
        H_SYNC: begin
          if (tmo_evt || fe_evt) hdr_state <= H_IDLE;
          else if (char_evt) hdr_state <= sync_bad ? H_IDLE : H_ID;
        end
        H_ID: begin
          if (tmo_evt || fe_evt || id_evt) hdr_state <= H_IDLE;
          if (id_evt) header_length_reg <= tmo_reg;
        end
        H_BLOCK: begin
          if (!ctrl_reg3[C3_BLOCKED]) hdr_state <= H_IDLE;
        end
        default: hdr_state <= H_IDLE;
      endcase
      if (brk_evt && slave_mode && hdr_state != H_BLOCK) begin
        hdr_state    <= auto_rs ? H_MEAS : H_SYNC;
        tmo_reg      <= 8'h00;
        edge_cnt_reg <= 3'h0;
      end
    end
  end

  // Transmitter with break generation
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state     <= T_IDLE;
      tsh_reg      <= 10'h3ff;
      tbits_reg    <= 4'h0;
      tx_out_reg   <= 1'b1;
      brk_pend_reg <= 1'b0;
    end else begin
      if (wr_c2 && wd[C2_BREAK] && !ctrl_reg2[C2_BREAK] && !slave_mode)
        brk_pend_reg <= 1'b1;
      if (tbit_tick) begin
        case (tx_state)
          T_IDLE: begin
            tx_out_reg <= 1'b1;
            tbits_reg  <= 4'h0;
            if (brk_pend_reg) begin
              tx_state     <= T_BRK;
              brk_pend_reg <= 1'b0;
              tx_out_reg   <= 1'b0;
            end else if (!status_reg[ST_TX_EMPTY]) begin
              tx_state   <= T_SHIFT;
              tsh_reg    <= {1'b1, tx_hold_reg, 1'b0};
              tx_out_reg <= 1'b0;
            end
          end
          T_SHIFT: begin
            tsh_reg    <= {1'b1, tsh_reg[9:1]};
            tx_out_reg <= tsh_reg[1];
            tbits_reg  <= tbits_reg + 4'h1;
            if (tbits_reg == 4'h9) tx_state <= T_IDLE;
          end
          T_BRK: begin
            tbits_reg <= tbits_reg + 4'h1;
            if (tbits_reg == TX_BRK_BITS - 4'h1) begin
              tx_out_reg <= 1'b1;
              tx_state   <= T_IDLE;
            end
          end
          default: tx_state <= T_IDLE;
        endcase
      end
    end
  end
endmodule

`default_nettype wire

// ### verification/lin_node_model.sv
// Remote LIN master node driving the receive line
`timescale 1ns/1ps
`default_nettype none

module lin_node_model #(
  parameter int BIT_CYC = 64
) (
  input wire logic ref_clk,
  output var logic line
);
  // Bus has a pull-up, so idle reads recessive
  initial line = 1'b1;

  task automatic hold(input logic v, input int n);
    line <= v;
    repeat (n * BIT_CYC) @(posedge ref_clk);
  endtask

  // Dominant run then one recessive bit
  task automatic send_low(input int n);
    hold(1'b0, n);
    hold(1'b1, 1);
  endtask

  // Start, eight bits LSB first, stop
  task automatic send_byte(input logic [7:0] b);
    hold(1'b0, 1);
    for (int i = 0; i < 8; i++) hold(b[i], 1);
    hold(1'b1, 1);
  endtask
endmodule

`default_nettype wire

// ### verification/lin_serial_header_logic_asserts.sv
// Port-level checker for the LIN header serial block
`timescale 1ns/1ps
`default_nettype none

module lin_serial_header_logic_asserts
  import lin_hdr_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       rst_n,
  input wire reg_req_t   reg_req,
  input wire logic [7:0] rd_data,
  input wire logic       rx_data_in,
  input wire logic       tx_data_out,
  input wire logic       cpu_irq_mask,
  input wire logic       irq_out
);
  logic [7:0] ext_rx_reg, ext_tx_reg;
  logic       lin_reg, slave_reg, rie_reg, hie_reg, tx_used_reg;
  wire        wr_c3 = reg_req.wr && reg_req.addr == CTRL3_ADDR;
  wire        wr_c2 = reg_req.wr && reg_req.addr == CTRL2_ADDR;
  wire        tx_go = (reg_req.wr && reg_req.addr == DATA_ADDR)
                      || (wr_c2 && reg_req.wdata[C2_BREAK] && !(lin_reg && slave_reg));

  // Shadow of what software wrote, as seen from the bus
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      {ext_rx_reg, ext_tx_reg} <= 16'h0000;
      {lin_reg, slave_reg, rie_reg, hie_reg, tx_used_reg} <= 5'h00;
    end else begin
      if (wr_c3) {hie_reg, slave_reg, lin_reg} <= reg_req.wdata[6:4];
      if (wr_c2) rie_reg <= reg_req.wdata[C2_RX_IRQ];
      if (reg_req.wr && reg_req.addr == EXT_RX_ADDR && !lin_reg) ext_rx_reg <= reg_req.wdata;
      if (reg_req.wr && reg_req.addr == EXT_TX_ADDR && !lin_reg) ext_tx_reg <= reg_req.wdata;
      tx_used_reg <= tx_used_reg | tx_go;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_rd(logic [3:0] a);
    reg_req.rd && reg_req.addr == a;
  endsequence

  property p_rd_idle;
    !reg_req.rd |=> rd_data == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
  property p_unmapped;
    reg_req.rd && reg_req.addr > 4'h7 |=> rd_data == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_ext_rx_rb;
    s_rd(EXT_RX_ADDR) ##0 !lin_reg |=> rd_data == ext_rx_reg;
  endproperty
  a_ext_rx_rb: assert property (p_ext_rx_rb) else $error("rx prescaler readback");
  property p_ext_tx_rb;
    s_rd(EXT_TX_ADDR) ##0 !lin_reg |=> rd_data == ext_tx_reg;
  endproperty
  a_ext_tx_rb: assert property (p_ext_tx_rb) else $error("tx prescaler readback");
  property p_status_idle;
    s_rd(STATUS_ADDR) ##0 !tx_used_reg |=> rd_data[ST_TX_EMPTY];
  endproperty
  a_status_idle: assert property (p_status_idle) else $error("tx empty not set");
  property p_slave_quiet;
    lin_reg && slave_reg && !tx_used_reg |-> tx_data_out;
  endproperty
  a_slave_quiet: assert property (p_slave_quiet) else $error("slave drove tx low");
  property p_mask;
    cpu_irq_mask |=> !irq_out;
  endproperty
  a_mask: assert property (p_mask) else $error("interrupt while masked");
  property p_irq_src;
    !(rie_reg || hie_reg) |=> !irq_out;
  endproperty
  a_irq_src: assert property (p_irq_src) else $error("interrupt with no enable");
endmodule

`default_nettype wire

// ### verification/lin_serial_header_logic_tb.sv
// Testbench for the LIN header serial block
`timescale 1ns/1ps
`default_nettype none

module lin_serial_header_logic_tb
  import lin_hdr_pkg::*;
;
  logic       ref_clk, rst_n, cpu_irq_mask, tx_data_out, irq_out;
  wire logic  rx_data_in;
  reg_req_t   reg_req;
  logic [7:0] rd_data, rv, c3, id;
  int         bad_count, checks_done, n;

  lin_serial_header_logic i_lin_serial_header_logic (.ref_clk(ref_clk), .rst_n(rst_n),
    .reg_req(reg_req), .rd_data(rd_data), .rx_data_in(rx_data_in),
    .tx_data_out(tx_data_out), .cpu_irq_mask(cpu_irq_mask), .irq_out(irq_out));
  lin_node_model #(.BIT_CYC(64)) i_lin_node_model (.ref_clk(ref_clk), .line(rx_data_in));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    reg_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    reg_req.rd <= 1'b0;
    #1 d = rd_data;
  endtask

  function automatic logic [7:0] lin_id(input logic [5:0] i);
    return {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4], i};
  endfunction

  task automatic send(input int lows, input logic [7:0] b);
    if (lows > 0) i_lin_node_model.send_low(lows);
    else i_lin_node_model.send_byte(b);
  endtask

  // Header flag, then status access followed by data read
  task automatic expect_rx(input logic [7:0] msk, input logic [7:0] st, input logic hdf,
                           input logic [7:0] dat);
    rd(CTRL3_ADDR, rv);
    check("header flag", {7'h00, hdf}, {7'h00, rv[C3_HDF]});
    rd(STATUS_ADDR, rv);
    check("status", st, rv & msk);
    rd(DATA_ADDR, rv);
    if (msk[ST_RX_FULL] && st[ST_RX_FULL]) check("data", dat, rv);
    if (hdf) wr(CTRL3_ADDR, c3);
  endtask

  task automatic brk_len(input logic [7:0] e);
    wr(CTRL3_ADDR, 8'h00);
    wr(EXT_TX_ADDR, e);
    wr(CTRL3_ADDR, 8'h10);
    wr(CTRL2_ADDR, 8'h01);
    wr(CTRL2_ADDR, 8'h00);
    n = 0;
    while (tx_data_out !== 1'b0 && n < 5000) begin
      @(posedge ref_clk);
      #1 n++;
    end
    n = 0;
    while (tx_data_out === 1'b0 && n < 20000) begin
      @(posedge ref_clk);
      #1 n++;
    end
    check("break bits", 8'(13 * ((e == 8'h00) ? 1 : e)), 8'(n / 16));
    check("break tail", 8'h00, 8'(n % 16));
  endtask

  initial begin
    #3_000_000;
    bad_count++;
    $display("watchdog expired");
    conclude();
  end

  initial begin
    reg_req = '0;
    cpu_irq_mask = 1'b0;
    rst_n = 1'b0;
    bad_count = 0;
    checks_done = 0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(STATUS_ADDR, rv);
    check("status reset", 8'h80, rv);
    rd(EXT_RX_ADDR, rv);
    check("rx prescaler reset", 8'h00, rv);
    rd(EXT_TX_ADDR, rv);
    check("tx prescaler reset", 8'h00, rv);
    rd(4'h8, rv);
    check("unmapped read", 8'h00, rv);
    $display("test reset values done");
    c3 = 8'h30;
    wr(CTRL1_ADDR, 8'h04);
    wr(CTRL3_ADDR, c3);
    wr(BAUD_ADDR, 8'h04);
    wr(EXT_TX_ADDR, 8'h00);
    wr(EXT_RX_ADDR, 8'h77);
    wr(CTRL2_ADDR, 8'h01);
    wr(CTRL2_ADDR, 8'h00);
    n = 0;
    for (int i = 0; i < 1000; i++) begin
      @(posedge ref_clk);
      #1 if (tx_data_out !== 1'b1) n++;
    end
    check("slave break ignored", 8'h00, (n == 0) ? 8'h00 : 8'hff);
    wr(CTRL3_ADDR, 8'h00);
    rd(EXT_RX_ADDR, rv);
    check("rx prescaler kept", 8'h00, rv);
    wr(EXT_RX_ADDR, 8'ha5);
    wr(EXT_TX_ADDR, 8'h3c);
    rd(EXT_RX_ADDR, rv);
    check("rx prescaler", 8'ha5, rv);
    rd(EXT_TX_ADDR, rv);
    check("tx prescaler", 8'h3c, rv);
    $display("test registers done");
    brk_len(8'h00);
    brk_len(8'h03);
    $display("test master break done");
    wr(CTRL3_ADDR, c3);
    wr(BAUD_ADDR, 8'h04);
    wr(EXT_TX_ADDR, 8'h00);
    wr(CTRL2_ADDR, 8'h20);
    send(10, 8'h00);
    expect_rx(8'h03, 8'h02, 1'b0, 8'h00);
    for (int k = 0; k < 2; k++) begin
      id = (k == 0) ? lin_id(6'h15) : lin_id(6'h2a) ^ 8'h80;
      send(13, 8'h00);
      expect_rx(8'h27, 8'h20, 1'b1, 8'h00);
      send(0, SYNC_BYTE);
      expect_rx(8'h27, 8'h20, 1'b0, SYNC_BYTE);
      send(0, id);
      expect_rx(8'h27, (k == 0) ? 8'h20 : 8'h24, 1'b0, id);
    end
    send(13, 8'h00);
    expect_rx(8'h27, 8'h20, 1'b1, 8'h00);
    @(posedge ref_clk);
    cpu_irq_mask <= 1'b1;
    send(0, 8'ha5);
    #1 check("masked irq", 8'h00, {7'h00, irq_out});
    @(posedge ref_clk);
    cpu_irq_mask <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1 check("irq", 8'h01, {7'h00, irq_out});
    expect_rx(8'h01, 8'h01, 1'b0, 8'h00);
    expect_rx(8'h01, 8'h00, 1'b0, 8'h00);
    $display("test method zero done");
    c3 = 8'h38;
    wr(CTRL3_ADDR, c3);
    id = lin_id(6'h33);
    send(13, 8'h00);
    expect_rx(8'h20, 8'h00, 1'b0, 8'h00);
    send(0, SYNC_BYTE);
    expect_rx(8'h20, 8'h00, 1'b0, 8'h00);
    send(0, id);
    expect_rx(8'h20, 8'h20, 1'b1, id);
    $display("test method one done");
    c3 = 8'h34;
    wr(CTRL3_ADDR, c3);
    send(13, 8'h00);
    expect_rx(8'h27, 8'h20, 1'b1, 8'h00);
    send(0, SYNC_BYTE);
    expect_rx(8'h27, 8'h00, 1'b0, 8'h00);
    send(0, id);
    expect_rx(8'h27, 8'h20, 1'b0, id);
    rd(BAUD_ADDR, rv);
    check("measured divider", 8'h04, rv);
    send(13, 8'h00);
    expect_rx(8'h27, 8'h20, 1'b1, 8'h00);
    repeat (3700) @(posedge ref_clk);
    rd(CTRL3_ADDR, rv);
    check("blocked flag", 8'h02, rv & 8'h02);
    wr(CTRL3_ADDR, c3);
    expect_rx(8'h01, 8'h01, 1'b0, 8'h00);
    $display("test resync done");
    conclude();
  end
endmodule

bind lin_serial_header_logic lin_serial_header_logic_asserts i_lin_serial_header_logic_asserts (
  .ref_clk(ref_clk), .rst_n(rst_n), .reg_req(reg_req), .rd_data(rd_data),
  .rx_data_in(rx_data_in), .tx_data_out(tx_data_out), .cpu_irq_mask(cpu_irq_mask),
  .irq_out(irq_out));

`default_nettype wire
